/* bench/bcs_chk.sv */
// Checker of bus handshakes and serial pin timing of the serial port.
`timescale 1ns/1ps
`default_nettype none
module bcs_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        sck_o,
  input wire logic        sck_oe,
  input wire logic        so,
  input wire logic        serial_done_irq
);
  // ==========
  // Assertions
  // ==========
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |->
                                ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  irq_pulse_a: assert property (serial_done_irq |=> !serial_done_irq) else $error("irq too long");
  tx_edge_a: assert property (sck_oe && !s_axi_bvalid && $changed(so) |-> !sck_o)
    else $error("data moved off falling edge");
  irq_edge_a: assert property (serial_done_irq && sck_oe |-> sck_o) else $error("irq with clock low");
  // Main scenarios reached.
  cover property (serial_done_irq);
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  cover property ($fell(sck_o));
endmodule
`default_nettype wire

/* bench/bcs_peer.sv */
// Model of an external serial peripheral on the clock and data pins.
`timescale 1ns/1ps
`default_nettype none
module bcs_peer (
  input  wire logic       aclk,
  input  wire logic       sck,
  input  wire logic       so,
  input  wire logic       load,
  input  wire logic [7:0] tx,
  output var  logic       si,
  output var  logic [7:0] rx
);
  logic       sck_q;
  logic [7:0] sh;
  // Present a bit after each falling pin edge and capture one after each rising edge.
  always_ff @(posedge aclk) begin
    sck_q <= sck;
    if (load) begin
      sh <= tx;
      si <= ~si;
      rx <= 8'h00;
    end else if (sck_q && !sck) begin
      si <= sh[0];
      sh <= {sh[0], sh[7:1]};
    end else if (!sck_q && sck) begin
      rx <= {so, rx[7:1]};
    end
  end
endmodule
`default_nettype wire

/* bench/tb.sv */
// Testbench of the buffered serial port over its register bus.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bcs_pkg::*;
  localparam logic [13:0] A_BUF = 14'h3e40;
  localparam logic [13:0] A_CA  = 14'h3e60;
  localparam logic [13:0] A_CB  = 14'h3e64;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sck_o, sck_oe, so;
  logic        serial_done_irq, sck_i, si, load, ext_sck;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  tx, rx;
  logic [13:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int          fails, checks_done;
  // The pin follows the bench's external clock, idling high, when the port does not drive it.
  assign sck_i = sck_oe ? sck_o : ext_sck;
  bcs_serial_io bcs_serial_io_i (.*, .ce(1'b1), .s_axi_awprot(3'h0), .s_axi_arprot(3'h0), .s_axi_wstrb(4'h1));
  bcs_peer bcs_peer_i (.aclk(aclk), .sck(sck_i), .so(so), .load(load), .tx(tx), .si(si), .rx(rx));
  // ================
  // Tasks
  // ================
  task automatic summarize;
    if (fails == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic lim(input int n, input int l);
    if (n >= l) begin
      fails++;
      $display("unexpected at %0t: timeout", $time);
      summarize();
    end
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    lim(n, 50);
    chk({6'h0, s_axi_bresp}, {6'h0, RESP_OKAY});
  endtask
  task automatic rd(input logic [13:0] a, input logic [7:0] m, input logic [7:0] e, input logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    lim(n, 50);
    chk(s_axi_rdata[7:0] & m, e);
    chk({6'h0, s_axi_rresp}, {6'h0, r});
  endtask
  task automatic wirq;
    int n;
    for (n = 0; n < 4000 && serial_done_irq !== 1'b1; n++) @(posedge aclk);
    lim(n, 4000);
    repeat (2) @(posedge aclk);
  endtask
  // Clock of 25 ns.
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // Main sequence: transmit, two receive bursts, a mode switch, then external-clock transmit.
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, tx} = '0;
    load = 1'b1;
    ext_sck = 1'b1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    load <= 1'b0;
    rd(A_CB, 8'hff, 8'h00, RESP_OKAY);
    rd(14'h0000, 8'hff, 8'h00, RESP_SLVERR);
    wr(A_BUF, 8'ha5);
    wr(A_CB, 8'h00);
    wr(A_CA, 8'h85);
    rd(A_CB, 8'h80, 8'h80, RESP_OKAY);
    wirq();
    chk(rx, 8'ha5);
    wr(A_CA, 8'h45);
    rd(A_CB, 8'hff, 8'h00, RESP_OKAY);
    for (int i = 0; i < 2; i++) begin
      tx <= 8'h3c;
      load <= 1'b1;
      @(posedge aclk);
      load <= 1'b0;
      wr(A_CB, i ? 8'h00 : 8'h01);
      wr(A_CA, i ? 8'hb5 : 8'had);
      wirq();
      rd(A_BUF, 8'hff, i ? 8'h0c : 8'h3c, RESP_OKAY);
      if (i == 0) rd(A_BUF + 14'h4, 8'hff, 8'h3c, RESP_OKAY);
      wr(A_CA, i ? 8'h75 : 8'h6d);
    end
    wr(A_CA, 8'h05);
    rd(A_BUF, 8'hff, 8'h00, RESP_OKAY);
    // External clock, pulses four cycles wide, start never cleared: one dummy word, then the end.
    wr(A_BUF, 8'h5a);
    wr(A_CA, 8'h87);
    for (int p = 0; p < 16; p++) begin
      repeat (4) @(posedge aclk);
      ext_sck <= 1'b0;
      repeat (4) @(posedge aclk);
      ext_sck <= 1'b1;
      if (p == 7 || p == 15) begin
        wirq();
        chk(rx, 8'h5a);
        rd(A_CB, 8'h80, (p == 7) ? 8'h80 : 8'h00, RESP_OKAY);
      end
    end
    summarize();
  end
endmodule
bind bcs_serial_io bcs_chk bcs_chk_i (.*);
`default_nettype wire

/* design/bcs_divider.sv */
// Divider that produces serial clock half-period ticks from the system clock.
`timescale 1ns/1ps
`default_nettype none

module bcs_divider
  import bcs_pkg::*;
#(
  parameter int unsigned CNT_W = 13
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [2:0] sel,
  output var  logic       tick
);

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] mask;

  // Maps a tap code to the low-bit mask of its half period (2^12, 2^7 .. 2^3).
  function automatic logic [CNT_W-1:0] half_mask(input logic [2:0] code);
    logic [CNT_W-1:0] m;
    m = '0;
    case (code)
      3'h0:    m = CNT_W'(13'h0fff);
      3'h1:    m = CNT_W'(13'h007f);
      3'h2:    m = CNT_W'(13'h003f);
      3'h3:    m = CNT_W'(13'h001f);
      3'h4:    m = CNT_W'(13'h000f);
      default: m = CNT_W'(13'h0007);
    endcase
    return m;
  endfunction

  assign mask = half_mask(sel);

  // Free counter, restarted whenever the serial clock is not running.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= '0;
    end else if (ce) begin
      cnt_ff <= run ? cnt_ff + 1'b1 : '0;
    end
  end

  // One-cycle tick at every half period of the selected tap.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick <= 1'b0;
    end else if (ce) begin
      tick <= run && ((cnt_ff & mask) == mask);
    end
  end

endmodule

`default_nettype wire

/* design/bcs_serial_io.sv */
// Buffered clocked serial port with an AXI4-Lite register slave.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Clock select codes 0-5 pick divider taps, 7 the external pin, 6 reserved.
// - Internal clock drives the clock pin, which is high when a transfer starts.
// - Internal clock halts and holds the next shift until the buffer is serviced.
// - Transmit data change on the falling serial clock edge.
// - Receive data are sampled on the rising serial clock edge.
// - Four-bit transfers use the low nibble; received upper nibble is zero.
// - Words are shifted least significant bit first.
// - Bursts of up to eight words; interrupt after the programmed count.
// - After a word's last bit the next buffer word loads into the shifter.
// - Transmit burst end raises the buffer-empty interrupt.
// - Internal-clock transmit waits without new data; one written word resumes.
// - Only a buffer write in a transmit mode or a buffer read in a receive mode cancels an automatic wait.
// - Clearing start while transmitting ends after the current word.
// - Abort ends at once and clears the active flag.
// - External transmit without start cleared sends dummy data, then ends.
// - Received words go to the buffer; buffer-full interrupt at the count.
// - Internal receive stalls before overwriting unread data; one read avoids it.
// - External receive with unread data stores nothing and cancels reception.
// - Clearing start while receiving stores the current word, then ends.
// - Changing the transfer mode clears the buffer.
// - Mode codes: 0 tx8, 2 tx4, 4 trx8, 5 rx8, 6 rx4, others reserved.
// - The buffer is eight consecutive entries used from the lowest upward.
// - Status register shows active flag in bit 7 and shift flag in bit 6.
module bcs_serial_io
  import bcs_pkg::*;
#(
  parameter int unsigned DIV_W = 13
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              sck_i,
  output var  logic              sck_o,
  output var  logic              sck_oe,
  input  wire logic              si,
  output var  logic              so,
  output var  logic              serial_done_irq
);

  // ==========================================================================
  // Decoding helpers
  // ==========================================================================
  // True for modes that shift data out.
  function automatic logic mode_tx(input logic [2:0] m);
    return (m == MODE_TX8) || (m == MODE_TX4) || (m == MODE_TRX8);
  endfunction

  // True for modes that store received data.
  function automatic logic mode_rx(input logic [2:0] m);
    return (m == MODE_RX8) || (m == MODE_RX4) || (m == MODE_TRX8);
  endfunction

  // True for the four-bit modes.
  function automatic logic mode_nib(input logic [2:0] m);
    return (m == MODE_TX4) || (m == MODE_RX4);
  endfunction

  // True when a register index falls in the data buffer.
  function automatic logic is_buf(input logic [11:0] idx);
    return (idx >= IDX_BUF_LO) && (idx <= IDX_BUF_HI);
  endfunction

  // ==========================================================================
  // Declarations
  // ==========================================================================
  bcs_ctrl_a_t       ctrl_a_ff;
  logic [2:0]        buf_cnt_ff;
  logic [7:0]        buf_ff [BUF_WORDS];
  bcs_state_t        state_ff;
  logic              active_ff;
  logic              dummy_ff;
  logic              touched_ff;
  logic              owe_ff;
  logic [2:0]        word_ff;
  logic [2:0]        bit_ff;
  logic [7:0]        sh_ff;
  logic              sck_prev_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [7:0]        wdata_ff;
  logic              wstrb0_ff;
  logic              tick;

  logic        is_ext;
  logic        is_tx;
  logic        is_rx;
  logic        is_nib;
  logic [11:0] wr_idx;
  logic [11:0] rd_idx;
  logic        wr_fire;
  logic        wr_ctrl_a;
  logic        wr_buf;
  logic        rd_fire;
  logic        sw_touch;
  bcs_ctrl_a_t ca_w;
  logic        start_go;
  logic        abort_go;
  logic        mode_chg;
  logic        running;
  logic        fall_ev;
  logic        rise_ev;
  logic        last_bit;
  logic        word_end;
  logic        burst_end;
  logic        ext_overrun;
  logic        rx_store;
  logic [7:0]  sh_in;
  logic [2:0]  word_nxt;

  // ==========================================================================
  // Event decoding
  // ==========================================================================
  // Mode and clock source decode.
  assign is_ext  = (ctrl_a_ff.clk_sel == CLK_EXT);
  assign is_tx   = mode_tx(ctrl_a_ff.mode);
  assign is_rx   = mode_rx(ctrl_a_ff.mode);
  assign is_nib  = mode_nib(ctrl_a_ff.mode);
  assign running = (state_ff == ST_RUN);

  // Software accesses, taken from the AXI channels.
  assign wr_idx    = aw_addr_ff[ADDR_W-1:2];
  assign rd_idx    = s_axi_araddr[ADDR_W-1:2];
  assign wr_fire   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign rd_fire   = s_axi_arvalid && s_axi_arready;
  assign wr_ctrl_a = wr_fire && wstrb0_ff && (wr_idx == IDX_CTRL_A);
  assign wr_buf    = wr_fire && wstrb0_ff && is_buf(wr_idx);
  assign sw_touch  = (wr_buf && is_tx) || (rd_fire && is_buf(rd_idx) && is_rx);
  assign ca_w      = bcs_ctrl_a_t'(wdata_ff);

  // Start, abort and mode change commands.
  assign start_go = wr_ctrl_a && ca_w.start && !ca_w.abort && (state_ff == ST_IDLE) &&
                    (mode_tx(ca_w.mode) || mode_rx(ca_w.mode)) && (ca_w.clk_sel != CLK_RSVD);
  assign abort_go = wr_ctrl_a && ca_w.abort;
  assign mode_chg = wr_ctrl_a && (ca_w.mode != ctrl_a_ff.mode);

  // Serial clock edges, from the divider or from the pin.
  assign fall_ev = running && (is_ext ? (sck_prev_ff && !sck_i) : (tick && sck_o));
  assign rise_ev = running && (is_ext ? (!sck_prev_ff && sck_i) : (tick && !sck_o));

  // Word and burst boundaries.
  assign last_bit    = (bit_ff == (is_nib ? LAST_BIT_4 : LAST_BIT_8));
  assign word_end    = rise_ev && last_bit;
  assign burst_end   = word_end && ((word_ff == buf_cnt_ff) || dummy_ff);
  assign ext_overrun = is_rx && is_ext && owe_ff;
  assign rx_store    = word_end && is_rx && !ext_overrun;
  assign word_nxt    = word_ff + 3'h1;

  // Next shifter value: right shift, receive bit into the top of the word.
  assign sh_in = is_nib ? {4'h0, si, sh_ff[3:1]} : {si, sh_ff[7:1]};

  // ==========================================================================
  // Clock divider
  // ==========================================================================
  bcs_divider #(
    .CNT_W (DIV_W)
  ) u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .run     (running && !is_ext),
    .sel     (ctrl_a_ff.clk_sel),
    .tick    (tick)
  );

  // ==========================================================================
  // AXI4-Lite slave
  // ==========================================================================
  // Write channels: address and data taken in either order, response after both.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_addr_ff    <= '0;
      wdata_ff      <= 8'h00;
      wstrb0_ff     <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_ff    <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_ff     <= s_axi_wdata[7:0];
        wstrb0_ff    <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        if (is_buf(wr_idx) || (wr_idx == IDX_CTRL_A) || (wr_idx == IDX_CTRL_B)) begin
          s_axi_bresp <= RESP_OKAY;
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read channel: one cycle from address to data; control A reads as zero, the control B index reads the status.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ce) begin
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= RESP_OKAY;
        if (is_buf(rd_idx)) begin
          s_axi_rdata <= {24'h000000, buf_ff[rd_idx[2:0]]};
        end else if (rd_idx == IDX_STATE) begin
          s_axi_rdata <= 32'(({7'h00, active_ff} << ST_ACTIVE_BIT) |
                             ({7'h00, running} << ST_SHIFT_BIT));
        end else if (rd_idx == IDX_CTRL_A) begin
          s_axi_rdata <= 32'h0000_0000;
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Control registers
  // ==========================================================================
  // Control A; the abort bit clears itself and also drops the start flag.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a_ff <= bcs_ctrl_a_t'(CTRL_A_RESET);
    end else if (ce && wr_ctrl_a) begin
      ctrl_a_ff       <= ca_w;
      ctrl_a_ff.abort <= 1'b0;
      if (ca_w.abort) begin
        ctrl_a_ff.start <= 1'b0;
      end
    end
  end

  // Word count; software rewrites it in any state, even while shifting.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_cnt_ff <= BUF_CNT_RESET;
    end else if (ce && wr_fire && wstrb0_ff && (wr_idx == IDX_CTRL_B)) begin
      buf_cnt_ff <= wdata_ff[2:0];
    end
  end

  // ==========================================================================
  // Data buffer
  // ==========================================================================
  // Each entry: cleared on mode change, then received word, then software write.
  for (genvar gi = 0; gi < BUF_WORDS; gi++) begin : g_buf
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        buf_ff[gi] <= 8'h00;
      end else if (ce) begin
        if (mode_chg) begin
          buf_ff[gi] <= 8'h00;
        end else if (rx_store && (word_ff == 3'(gi))) begin
          buf_ff[gi] <= sh_in;
        end else if (wr_buf && (wr_idx[2:0] == 3'(gi))) begin
          buf_ff[gi] <= wdata_ff;
        end
      end
    end
  end

  // ==========================================================================
  // Service tracking
  // ==========================================================================
  // Touched: buffer serviced during this burst; a touch in the end cycle wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      touched_ff <= 1'b0;
    end else if (ce) begin
      if (sw_touch) begin
        touched_ff <= 1'b1;
      end else if (burst_end || start_go) begin
        touched_ff <= 1'b0;
      end
    end
  end

  // Owe: a burst ended with the buffer unserviced; cleared by the next buffer service or a start.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      owe_ff <= 1'b0;
    end else if (ce) begin
      if (burst_end) begin
        owe_ff <= !(touched_ff || sw_touch);
      end else if (sw_touch || start_go) begin
        owe_ff <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Transfer engine
  // ==========================================================================
  // State, word and bit counters, shifter and the active flag.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff  <= ST_IDLE;
      active_ff <= 1'b0;
      dummy_ff  <= 1'b0;
      word_ff   <= 3'h0;
      bit_ff    <= 3'h0;
      sh_ff     <= 8'h00;
    end else if (ce) begin
      if (abort_go) begin
        state_ff  <= ST_IDLE;
        active_ff <= 1'b0;
        dummy_ff  <= 1'b0;
      end else begin
        case (state_ff)
          ST_IDLE: begin
            if (start_go) begin
              state_ff  <= ST_RUN;
              active_ff <= 1'b1;
              dummy_ff  <= 1'b0;
              word_ff   <= 3'h0;
              bit_ff    <= 3'h0;
              sh_ff     <= buf_ff[0];
            end
          end
          ST_RUN: begin
            if (rise_ev) begin
              sh_ff  <= sh_in;
              bit_ff <= last_bit ? 3'h0 : bit_ff + 3'h1;
            end
            if (word_end) begin
              if (ext_overrun || !ctrl_a_ff.start || (burst_end && dummy_ff)) begin
                state_ff  <= ST_IDLE;
                active_ff <= 1'b0;
                dummy_ff  <= 1'b0;
              end else if (burst_end) begin
                word_ff <= 3'h0;
                sh_ff   <= buf_ff[0];
                if (!(touched_ff || sw_touch)) begin
                  if (!is_ext) begin
                    state_ff <= ST_WAIT;
                  end else if (is_tx && !is_rx) begin
                    dummy_ff <= 1'b1;
                  end
                end
              end else begin
                word_ff <= word_nxt;
                sh_ff   <= buf_ff[word_nxt];
              end
            end
          end
          ST_WAIT: begin
            if (!ctrl_a_ff.start) begin
              state_ff  <= ST_IDLE;
              active_ff <= 1'b0;
            end else if (!owe_ff) begin
              state_ff <= ST_RUN;
              word_ff  <= 3'h0;
              bit_ff   <= 3'h0;
              sh_ff    <= buf_ff[0];
            end
          end
          default: begin
            state_ff  <= ST_IDLE;
            active_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Pins and interrupt
  // ==========================================================================
  // Serial clock: high at start and while halted, toggled on divider ticks.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_o       <= 1'b1;
      sck_oe      <= 1'b0;
      sck_prev_ff <= 1'b1;
    end else if (ce) begin
      sck_prev_ff <= sck_i;
      sck_oe      <= (ctrl_a_ff.clk_sel <= CLK_TAP_MAX);
      if (running && !is_ext && tick && !(word_end && state_ff != ST_RUN)) begin
        sck_o <= !sck_o;
      end else if (!running) begin
        sck_o <= 1'b1;
      end
    end
  end

  // Transmit bit changes on the falling edge, low bit first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      so <= 1'b1;
    end else if (ce && fall_ev && is_tx) begin
      so <= sh_ff[0];
    end
  end

  // One-cycle completion pulse: buffer empty in transmit, full in receive.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_done_irq <= 1'b0;
    end else if (ce) begin
      serial_done_irq <= burst_end && !ext_overrun && !abort_go;
    end
  end

endmodule

`default_nettype wire

/* pkg/bcs_pkg.sv */
// Package with the register map, field layouts, mode codes and types of the buffered serial port.
package bcs_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  // Register indices; the AXI4-Lite byte address is four times the index.
  localparam int unsigned    ADDR_W       = 14;
  localparam int unsigned    BUF_WORDS    = 8;
  localparam logic [11:0]    IDX_BUF_LO   = 12'hf90;
  localparam logic [11:0]    IDX_BUF_HI   = 12'hf97;
  localparam logic [11:0]    IDX_CTRL_A   = 12'hf98;
  localparam logic [11:0]    IDX_CTRL_B   = 12'hf99;
  localparam logic [11:0]    IDX_STATE    = 12'hf99;

  // Reset values of the control registers.
  localparam logic [7:0]     CTRL_A_RESET = 8'h00;
  localparam logic [2:0]     BUF_CNT_RESET = 3'h0;

  // Status register bit positions.
  localparam int unsigned    ST_ACTIVE_BIT = 7;
  localparam int unsigned    ST_SHIFT_BIT  = 6;

  // ==========================================================================
  // Field encodings
  // ==========================================================================
  localparam logic [2:0]     MODE_TX8     = 3'h0;
  localparam logic [2:0]     MODE_TX4     = 3'h2;
  localparam logic [2:0]     MODE_TRX8    = 3'h4;
  localparam logic [2:0]     MODE_RX8     = 3'h5;
  localparam logic [2:0]     MODE_RX4     = 3'h6;
  localparam logic [2:0]     CLK_TAP_MAX  = 3'h5;
  localparam logic [2:0]     CLK_RSVD     = 3'h6;
  localparam logic [2:0]     CLK_EXT      = 3'h7;
  localparam logic [2:0]     LAST_BIT_8   = 3'h7;
  localparam logic [2:0]     LAST_BIT_4   = 3'h3;
  localparam logic [1:0]     RESP_OKAY    = 2'h0;
  localparam logic [1:0]     RESP_SLVERR  = 2'h2;

  // ==========================================================================
  // Types
  // ==========================================================================
  // Control register A, laid out as its bits 7 down to 0.
  typedef struct packed {
    logic       start;
    logic       abort;
    logic [2:0] mode;
    logic [2:0] clk_sel;
  } bcs_ctrl_a_t;

  // Transfer engine states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_WAIT = 3'b100
  } bcs_state_t;

endpackage
